// [src/lcd_pkg.sv]
// Constants shared by the LCD instruction decoder.
// Assumes a single 20 MHz clock domain.
package lcd_pkg;

    // =====================================================
    // Address counter and memory geometry
    localparam int COUNT_W = 7;
    localparam logic [6:0] DD_LINE1_FIRST = 7'h00;
    localparam logic [6:0] DD_LINE1_LAST = 7'h0B;
    localparam logic [6:0] DD_LINE2_FIRST = 7'h40;
    localparam logic [6:0] DD_LINE2_LAST = 7'h4B;
    localparam logic [3:0] LAST_COL = 4'hB;
    localparam logic [4:0] LINE_LEN = 5'h0C;
    localparam int DD_DEPTH = 24;
    localparam int CG_DEPTH = 32;

    // =====================================================
    // Instruction bit positions
    localparam int BIT_DD_SET = 7;
    localparam int BIT_CG_SET = 6;
    localparam int BIT_FUNC = 5;
    localparam int BIT_SHIFT = 4;
    localparam int BIT_FUNC_ONE = 3;
    localparam int BIT_WIDTH = 4;
    localparam int BIT_SHIFT_DISP = 3;
    localparam int BIT_SHIFT_RIGHT = 2;
    localparam int BIT_LINE = 6;

    // =====================================================
    // Software register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_OFFSET = 8'h08;
    localparam logic [7:0] REG_MEM_INDEX = 8'h0C;
    localparam logic [7:0] REG_MEM_DATA = 8'h10;
    localparam int CTRL_INC = 0;
    localparam int CTRL_SHIFT = 1;
    localparam int INDEX_GLYPH = 7;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic WIDTH_RESET = 1'h1;

    // =====================================================
    // Execution time of one accepted instruction or write
    localparam int EXEC_TIME_NS = 40000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {LCD_NIB_HIGH, LCD_NIB_LOW} lcd_nibble_t;

endpackage : lcd_pkg

// [src/lcd_instr_decoder.sv]
// Instruction decoder for a 12x2 character LCD controller.
// Host pins arrive asynchronously and are synchronised here; the
// software port and clk_en come from logic on the same clock.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module lcd_instr_decoder
    import lcd_pkg::*;
#(
    parameter int unsigned EXEC_CYCLES_P = EXEC_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic register_select,
    input wire logic read_write,
    input wire logic bus_enable,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic serial_mode,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    localparam int BUSY_W = $clog2(EXEC_CYCLES_P + 1);

    // =====================================================
    // Address stepping and display offset helpers
    // addresses
    function automatic logic [6:0] step_address(input logic [6:0] cur, input logic up,
                                                input logic glyph);
        logic [6:0] r;
        r = up ? cur + 7'h01 : cur - 7'h01;
        if (glyph) begin
            r = {2'h0, r[4:0]};
        end else if (up && cur == DD_LINE1_LAST) begin
            r = DD_LINE2_FIRST;
        end else if (up && cur == DD_LINE2_LAST) begin
            r = DD_LINE1_FIRST;
        end else if (!up && cur == DD_LINE2_FIRST) begin
            r = DD_LINE1_LAST;
        end else if (!up && cur == DD_LINE1_FIRST) begin
            r = DD_LINE2_LAST;
        end
        return r;
    endfunction : step_address

    // Offset is the first shown column; both lines share it
    function automatic logic [3:0] next_offset(input logic [3:0] off, input logic left);
        if (left) begin
            return (off == LAST_COL) ? 4'h0 : off + 4'h1;
        end
        return (off == 4'h0) ? LAST_COL : off - 4'h1;
    endfunction : next_offset

    function automatic logic dd_ok(input logic [6:0] a);
        return (a <= DD_LINE1_LAST) ||
               (a >= DD_LINE2_FIRST && a <= DD_LINE2_LAST);
    endfunction : dd_ok

    function automatic logic [4:0] dd_index(input logic [6:0] a);
        return a[BIT_LINE] ? LINE_LEN + {1'h0, a[3:0]} : {1'h0, a[3:0]};
    endfunction : dd_index

    // =====================================================
    // Pin synchronisers
    logic [1:0] sel_sync;
    logic [1:0] rw_sync;
    logic [1:0] ps_sync;
    logic [2:0] en_sync;
    logic [7:0] db_meta;
    logic [7:0] db_sync;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sel_sync <= 2'h0;
            rw_sync <= 2'h0;
            ps_sync <= 2'h0;
            en_sync <= 3'h0;
            db_meta <= 8'h00;
            db_sync <= 8'h00;
        end else if (clk_en) begin
            sel_sync <= {sel_sync[0], register_select};
            rw_sync <= {rw_sync[0], read_write};
            ps_sync <= {ps_sync[0], serial_mode};
            en_sync <= {en_sync[1:0], bus_enable};
            db_meta <= data_in;
            db_sync <= db_meta;
        end
    end

    // =====================================================
    // State
    logic [6:0] address_counter;
    logic glyph_sel;
    logic width8;
    logic [3:0] offset;
    logic entry_inc;
    logic entry_shift;
    logic [BUSY_W-1:0] busy_cnt;
    lcd_nibble_t nib;
    logic [3:0] nib_hi;
    logic [7:0] mem_index;
    logic [7:0] dd_mem [DD_DEPTH];
    logic [4:0] cg_mem [CG_DEPTH];

    // =====================================================
    // Host transfer assembly
    logic strobe;
    logic four_bit;
    logic busy;
    logic byte_done;
    logic [7:0] host_byte;
    logic write_cmd;
    logic write_data;
    logic [7:0] status;

    always_comb begin
        // Bytes are taken on the falling edge of the enable pin
        strobe = en_sync[2] & ~en_sync[1];
        four_bit = ~width8 & ~ps_sync[1];
        busy = busy_cnt != '0;
        byte_done = strobe & (~four_bit | nib == LCD_NIB_LOW);
        host_byte = four_bit ? {nib_hi, db_sync[7:4]} : db_sync;
        write_cmd = clk_en & byte_done & ~sel_sync[1] & ~rw_sync[1] & ~busy;
        write_data = clk_en & byte_done & sel_sync[1] & ~rw_sync[1] & ~busy;
        status = {busy, address_counter};
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            nib <= LCD_NIB_HIGH;
            nib_hi <= 4'h0;
        end else if (clk_en && strobe) begin
            if (!four_bit) begin
                nib <= LCD_NIB_HIGH;
            end else if (nib == LCD_NIB_HIGH) begin
                nib <= LCD_NIB_LOW;
                nib_hi <= db_sync[7:4];
            end else begin
                nib <= LCD_NIB_HIGH;
            end
        end
    end

    // =====================================================
    // Address counter and memory select
    always_ff @(posedge clk) begin
        if (!resetn) begin
            address_counter <= DD_LINE1_FIRST;
            glyph_sel <= 1'h0;
        end else if (write_cmd) begin
            if (host_byte[BIT_DD_SET]) begin
                address_counter <= host_byte[6:0];
                glyph_sel <= 1'h0;
            end else if (host_byte[BIT_CG_SET]) begin
                address_counter <= {2'h0, host_byte[4:0]};
                glyph_sel <= 1'h1;
            end else if (!host_byte[BIT_FUNC] && host_byte[BIT_SHIFT]
                         && !host_byte[BIT_SHIFT_DISP]) begin
                address_counter <= step_address(address_counter,
                                                host_byte[BIT_SHIFT_RIGHT], glyph_sel);
            end
        end else if (write_data) begin
            address_counter <= step_address(address_counter, entry_inc, glyph_sel);
        end
    end

    // =====================================================
    // Interface width
    always_ff @(posedge clk) begin
        if (!resetn) begin
            width8 <= WIDTH_RESET;
        end else if (write_cmd && host_byte[7:5] == 3'h1 && host_byte[BIT_FUNC_ONE]
                     && !ps_sync[1]) begin
            width8 <= host_byte[BIT_WIDTH];
        end
    end

    // =====================================================
    // Display offset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            offset <= 4'h0;
        end else if (write_cmd && host_byte[7:4] == 4'h1 && host_byte[BIT_SHIFT_DISP]) begin
            offset <= next_offset(offset, ~host_byte[BIT_SHIFT_RIGHT]);
        end else if (write_data && !glyph_sel && entry_shift) begin
            offset <= next_offset(offset, entry_inc);
        end
    end

    // =====================================================
    // Memories; no reset, contents are data only
    always_ff @(posedge clk) begin
        if (write_data) begin
            if (glyph_sel) begin
                cg_mem[address_counter[4:0]] <= host_byte[4:0];
            end else if (dd_ok(address_counter)) begin
                dd_mem[dd_index(address_counter)] <= host_byte;
            end
        end
    end

    // =====================================================
    // Busy timer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_cnt <= '0;
        end else if (write_cmd || write_data) begin
            busy_cnt <= BUSY_W'(EXEC_CYCLES_P);
        end else if (clk_en && busy) begin
            busy_cnt <= busy_cnt - BUSY_W'(1);
        end
    end

    // =====================================================
    // Host read path: only status is returned
    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_out <= 8'h00;
            data_oe <= 1'h0;
        end else if (clk_en) begin
            data_oe <= en_sync[1] & ~sel_sync[1] & rw_sync[1];
            if (!four_bit) begin
                data_out <= status;
            end else if (nib == LCD_NIB_HIGH) begin
                data_out <= {status[7:4], 4'h0};
            end else begin
                data_out <= {status[3:0], 4'h0};
            end
        end
    end

    // =====================================================
    // Software port
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {entry_shift, entry_inc} <= CTRL_RESET;
            mem_index <= 8'h00;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                entry_inc <= reg_wdata[CTRL_INC];
                entry_shift <= reg_wdata[CTRL_SHIFT];
            end
            if (reg_addr == REG_MEM_INDEX) begin
                mem_index <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 32'h0;
        end else if (clk_en) begin
            reg_rdata <= 32'h0;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_CTRL: reg_rdata <= {30'h0, entry_shift, entry_inc};
                    REG_STATUS: reg_rdata <= {20'h0, ps_sync[1], width8,
                                              glyph_sel, busy, 1'h0, address_counter};
                    REG_OFFSET: reg_rdata <= {28'h0, offset};
                    REG_MEM_INDEX: reg_rdata <= {24'h0, mem_index};
                    REG_MEM_DATA: reg_rdata <= mem_index[INDEX_GLYPH]
                        ? {27'h0, cg_mem[mem_index[4:0]]}
                        : {24'h0, dd_ok(mem_index[6:0])
                                  ? dd_mem[dd_index(mem_index[6:0])] : 8'h00};
                    default: reg_rdata <= 32'h0;
                endcase
            end
        end
    end

    // =====================================================
    // Checks
    a_dd_addr_load: assert property (@(posedge clk) disable iff (!resetn)
        write_cmd && host_byte[7] |=> address_counter == $past(host_byte[6:0]) && !glyph_sel)
        else $error("display address set not loaded");

    a_cg_addr_load: assert property (@(posedge clk) disable iff (!resetn)
        write_cmd && host_byte[7:6] == 2'h1
        |=> address_counter == {2'h0, $past(host_byte[4:0])} && glyph_sel)
        else $error("glyph address set not loaded");

    a_cursor_line_wrap: assert property (@(posedge clk) disable iff (!resetn)
        write_cmd && host_byte[7:2] == 6'h05 && !glyph_sel && address_counter == DD_LINE1_LAST
        |=> address_counter == DD_LINE2_FIRST)
        else $error("cursor did not move to second line");

    a_display_shift_ac: assert property (@(posedge clk) disable iff (!resetn)
        write_cmd && host_byte[7:3] == 5'h03
        |=> $stable(address_counter) && offset != $past(offset))
        else $error("display shift changed counter or missed offset");

    a_offset_range: assert property (@(posedge clk) disable iff (!resetn)
        offset <= LAST_COL)
        else $error("display offset out of line");

    a_width_select: assert property (@(posedge clk) disable iff (!resetn)
        write_cmd && host_byte[7:5] == 3'h1 && host_byte[3] && !ps_sync[1]
        |=> width8 == $past(host_byte[4]))
        else $error("width selector not applied");

    a_serial_width: assert property (@(posedge clk) disable iff (!resetn)
        ps_sync[1] |=> $stable(width8))
        else $error("width changed in serial mode");

    a_busy_start: assert property (@(posedge clk) disable iff (!resetn)
        write_cmd || write_data |=> busy_cnt == BUSY_W'(EXEC_CYCLES_P) ##1 busy)
        else $error("busy not held after accepted access");

    a_status_byte: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && !four_bit |=> data_out == {$past(busy), $past(address_counter)})
        else $error("status byte wrong");

    a_write_step: assert property (@(posedge clk) disable iff (!resetn)
        write_data && !glyph_sel && address_counter == DD_LINE2_LAST && entry_inc
        |=> address_counter == DD_LINE1_FIRST)
        else $error("counter did not step after write");

    a_glyph_store: assert property (@(posedge clk) disable iff (!resetn)
        write_data && glyph_sel |=> cg_mem[$past(address_counter[4:0])] == $past(host_byte[4:0])
        && $stable(offset))
        else $error("glyph write wrong or shifted display");

    a_auto_shift: assert property (@(posedge clk) disable iff (!resetn)
        write_data && !glyph_sel && entry_shift && entry_inc
        |=> offset == next_offset($past(offset), 1'h1))
        else $error("auto shift direction wrong");

endmodule : lcd_instr_decoder

`default_nettype wire

// [tb/lcd_host_model.sv]
// Host processor model driving the parallel bus pins of the decoder.
// Assumes one free-running clock; tasks are called from the bench.
`timescale 1ns/100ps
`default_nettype none

module lcd_host_model
    import lcd_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic register_select,
    output logic read_write,
    output logic bus_enable,
    output logic [7:0] data_in
);
    logic [7:0] host_data = 8'h00;
    logic nibble_mode = 1'b0;

    initial begin
        register_select = 1'b0;
        read_write = 1'b0;
        bus_enable = 1'b0;
    end

    // Shared data lines: device wins while it drives, else our own value
    assign data_in = data_oe ? data_out : host_data;

    // =====================================================
    // One enable pulse
    // Released lines show the inverse of the last value, never a stale copy
    task automatic pulse(input logic sel, input logic rw, input logic [7:0] val,
                         output logic [7:0] seen, output logic oe);
        @(posedge clk);
        register_select <= sel;
        read_write <= rw;
        host_data <= rw ? ~host_data : val;
        @(posedge clk);
        bus_enable <= 1'b1;
        repeat (4) @(posedge clk);
        // Look between edges so the status byte has settled
        @(negedge clk);
        seen = data_out;
        oe = data_oe;
        @(posedge clk);
        bus_enable <= 1'b0;
        repeat (4) @(posedge clk);
        host_data <= ~host_data;
    endtask : pulse

    // =====================================================
    // Whole byte and status transfers
    // nibble pair split
    task automatic xfer(input logic sel, input logic [7:0] val);
        logic [7:0] s;
        logic o;
        if (nibble_mode) begin
            pulse(sel, 1'b0, {val[7:4], 4'h0}, s, o);
            pulse(sel, 1'b0, {val[3:0], 4'h0}, s, o);
        end else begin
            pulse(sel, 1'b0, val, s, o);
        end
    endtask : xfer

    task automatic status(output logic [7:0] st, output logic oe_ok);
        logic [7:0] hi;
        logic [7:0] lo;
        logic oh;
        logic ol;
        pulse(1'b0, 1'b1, 8'h00, hi, oh);
        if (nibble_mode) begin
            pulse(1'b0, 1'b1, 8'h00, lo, ol);
            st = {hi[7:4], lo[7:4]};
            oe_ok = oh & ol;
        end else begin
            st = hi;
            oe_ok = oh;
        end
    endtask : status

    task automatic wait_ready(output logic ok);
        logic [7:0] st;
        logic o;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            status(st, o);
            ok = (st[7] === 1'b0);
        end
    endtask : wait_ready

endmodule : lcd_host_model
`default_nettype wire

// [tb/lcd_instruction_decoder_tb.sv]
// Self-checking bench for the LCD instruction decoder.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("ERROR %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module lcd_instruction_decoder_tb
    import lcd_pkg::*;
();
    // Short busy time keeps the run brief but still visible to polls
    localparam int EXEC_SIM = 40;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic serial_mode = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nib_next = 1'b0;
    wire logic [31:0] reg_rdata;
    wire logic [7:0] data_out;
    wire logic [7:0] data_in;
    wire logic data_oe;
    wire logic register_select;
    wire logic read_write;
    wire logic bus_enable;
    int num_errors = 0;
    int total_checks = 0;

    always #25 clk = ~clk;

    lcd_instr_decoder #(.EXEC_CYCLES_P(EXEC_SIM)) i_dut (.clk(clk), .resetn(resetn),
        .clk_en(1'b1), .register_select(register_select), .read_write(read_write),
        .bus_enable(bus_enable), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .serial_mode(serial_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    lcd_host_model i_host (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .register_select(register_select), .read_write(read_write),
        .bus_enable(bus_enable), .data_in(data_in));

    // =====================================================
    // Software port and host helpers
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] m,
                           input logic [31:0] exp);
        logic [31:0] d;
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata & m;
        `CHK(nm, exp, d);
    endtask : chk_reg

    task automatic mem_check(input logic [7:0] idx, input logic [31:0] exp);
        reg_write(REG_MEM_INDEX, {24'h0, idx});
        chk_reg("mem", REG_MEM_DATA, 32'hFF, exp);
    endtask : mem_check

    task automatic instr(input logic sel, input logic [7:0] b);
        logic ok;
        i_host.xfer(sel, b);
        i_host.nibble_mode = nib_next;
        chk_reg("busy", REG_STATUS, 32'h100, 32'h100);
        i_host.wait_ready(ok);
        `CHK("ready", 1'b1, ok);
    endtask : instr

    task automatic chk_address(input logic [6:0] exp_addr);
        logic [7:0] st;
        logic oe;
        i_host.status(st, oe);
        `CHK("status", {1'b0, exp_addr}, st);
        `CHK("drive", 1'b1, oe);
    endtask : chk_address

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

    // =====================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk_reg("ctrl", REG_CTRL, 32'h3, 32'h1);
        chk_reg("status", REG_STATUS, 32'hF7F, 32'h400);
        chk_reg("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
        instr(1'b0, 8'h3F);
        chk_reg("width", REG_STATUS, 32'h400, 32'h400);
        // A byte that arrives while busy must be dropped
        i_host.xfer(1'b0, 8'h90);
        instr(1'b0, 8'h8F);
        chk_address(7'h10);
        instr(1'b0, 8'h8A);
        chk_address(7'h0A);
        instr(1'b1, 8'hA5);
        chk_address(DD_LINE1_LAST);
        instr(1'b1, 8'h5C);
        chk_address(DD_LINE2_FIRST);
        mem_check(8'h0A, 32'hA5);
        mem_check(8'h0B, 32'h5C);
        instr(1'b0, 8'h10);
        chk_address(DD_LINE1_LAST);
        instr(1'b0, 8'h17);
        chk_address(DD_LINE2_FIRST);
        instr(1'b0, 8'h18);
        chk_reg("offset", REG_OFFSET, 32'hF, 32'h1);
        chk_address(DD_LINE2_FIRST);
        instr(1'b0, 8'h1C);
        chk_reg("offset", REG_OFFSET, 32'hF, 32'h0);
        instr(1'b0, 8'h1E);
        chk_reg("offset", REG_OFFSET, 32'hF, 32'hB);
        mem_check(8'h0A, 32'hA5);
        instr(1'b0, 8'h65);
        chk_reg("glyph", REG_STATUS, 32'h27F, 32'h205);
        instr(1'b1, 8'hFF);
        chk_address(7'h06);
        mem_check(8'h85, 32'h1F);
        reg_write(REG_CTRL, 32'h2);
        instr(1'b1, 8'hE0);
        chk_address(7'h05);
        mem_check(8'h86, 32'h00);
        chk_reg("offset", REG_OFFSET, 32'hF, 32'hB);
        instr(1'b0, 8'h83);
        instr(1'b1, 8'h33);
        chk_address(7'h02);
        chk_reg("offset", REG_OFFSET, 32'hF, 32'hA);
        mem_check(8'h03, 32'h33);
        reg_write(REG_CTRL, 32'h3);
        nib_next = 1'b1;
        instr(1'b0, 8'h28);
        chk_reg("width", REG_STATUS, 32'h400, 32'h0);
        instr(1'b0, 8'hC5);
        chk_address(7'h45);
        // Write the last second-line cell in nibbles; counter wraps, image shifts left
        instr(1'b0, 8'hCB);
        instr(1'b1, 8'h77);
        chk_address(DD_LINE1_FIRST);
        chk_reg("offset", REG_OFFSET, 32'hF, 32'hB);
        mem_check(8'h4B, 32'h77);
        serial_mode <= 1'b1;
        nib_next = 1'b0;
        i_host.nibble_mode = 1'b0;
        repeat (4) @(posedge clk);
        instr(1'b0, 8'h87);
        chk_address(7'h07);
        instr(1'b0, 8'h38);
        chk_reg("width", REG_STATUS, 32'hC00, 32'h800);
        give_verdict();
    end

endmodule : lcd_instruction_decoder_tb
`default_nettype wire
